// ---- rtl/tup_pkg.sv ----
// Constants and types for the timed unlock and in-system programming block
package tup_pkg;
	localparam int REG_AW = 10;
	localparam logic [7:0] IDX_CLOCK_SELECT = 8'h8e;
	localparam logic [7:0] IDX_CHIP_PROG = 8'hbf;
	localparam logic [7:0] IDX_FLASH_ADDR_LOW = 8'hc4;
	localparam logic [7:0] IDX_FLASH_ADDR_HIGH = 8'hc5;
	localparam logic [7:0] IDX_FLASH_DATA = 8'hc6;
	localparam logic [7:0] IDX_ISP_CONTROL = 8'hc7;
	localparam logic [7:0] IDX_STATUS = 8'hc8;
	localparam logic [7:0] IDX_UNLOCK = 8'hf6;
	localparam logic [7:0] UNLOCK_FIRST = 8'h87;
	localparam logic [7:0] UNLOCK_SECOND = 8'h59;
	localparam logic [1:0] UNLOCK_MC = 2'h3;
	localparam logic [1:0] WINDOW_MC = 2'h3;
	localparam logic [3:0] OSC_PER_MC_12T = 4'hc;
	localparam logic [3:0] OSC_PER_MC_6T = 4'h6;
	localparam int CSC_SIX_BIT = 0;
	localparam int CPC_ARM_BIT = 0;
	localparam logic [7:0] CPC_SOFT_RESET_MASK = 8'h83;
	localparam int ISP_BANK_BIT = 6;
	localparam int ISP_OE_BIT = 5;
	localparam int ISP_CE_BIT = 4;
	localparam logic [7:0] ISP_WRITE_MASK = 8'h7f;
	localparam logic [3:0] OP_READ = 4'h0;
	localparam logic [3:0] OP_PROGRAM = 4'h1;
	localparam logic [3:0] OP_ERASE = 4'h2;
	localparam int MAIN_FLASH_BYTES = 65536;
	localparam int LOADER_FLASH_BYTES = 4096;
	localparam int LOADER_AW = $clog2(LOADER_FLASH_BYTES);
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] STACK_INIT_WORD = 16'h0000;
	localparam logic [15:0] LOADER_RETURN_ADDR = 16'h0000;

	typedef enum logic [1:0] {
		LK_IDLE,
		LK_FIRST,
		LK_OPEN
	} tup_lock_state_t;
endpackage : tup_pkg

// ---- rtl/tup_unlock_if.sv ----
// Link between register front end and unlock sequencer
`timescale 1ns/1ps
`default_nettype none
interface tup_unlock_if;
	logic wr_stb;
	logic [7:0] wr_data;
	logic mc_tick;
	logic window_open;
	logic first_pending;
	modport ctrl (output wr_stb, output wr_data, output mc_tick, input window_open, input first_pending);
	modport seq (input wr_stb, input wr_data, input mc_tick, output window_open, output first_pending);
endinterface : tup_unlock_if
`default_nettype wire

// ---- rtl/tup_mc_tick.sv ----
// Machine cycle strobe from the core clock
`timescale 1ns/1ps
`default_nettype none
module tup_mc_tick #(
	parameter int CNT_W = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Mode and strobe
	input wire logic six_mode,
	output logic mc_tick
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic tick;
	} tup_tick_state_t;

	tup_tick_state_t s_reg, s_next;
	logic [CNT_W-1:0] last;

	always_comb begin
		last = CNT_W'((six_mode ? tup_pkg::OSC_PER_MC_6T : tup_pkg::OSC_PER_MC_12T) - 4'h1);
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (s_reg.cnt >= last) begin
			s_next.cnt = '0;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign mc_tick = s_reg.tick;
endmodule : tup_mc_tick
`default_nettype wire

// ---- rtl/tup_unlock_seq.sv ----
// Two-step unlock sequencer and write window timer
`timescale 1ns/1ps
`default_nettype none
module tup_unlock_seq (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Front end link
	tup_unlock_if.seq lk
);
	typedef struct packed {
		tup_pkg::tup_lock_state_t st;
		logic [1:0] cnt;
	} tup_lock_reg_t;

	tup_lock_reg_t s_reg, s_next;
	logic expiring;

	assign expiring = lk.mc_tick && (s_reg.cnt == 2'h0);

	always_comb begin
		s_next = s_reg;
		if (s_reg.st != tup_pkg::LK_IDLE && lk.mc_tick) begin
			if (expiring) begin
				s_next.st = tup_pkg::LK_IDLE;
			end else begin
				s_next.cnt = s_reg.cnt - 2'h1;
			end
		end
		if (lk.wr_stb) begin
			case (lk.wr_data)
				tup_pkg::UNLOCK_FIRST: begin
					s_next.st = tup_pkg::LK_FIRST;
					s_next.cnt = tup_pkg::UNLOCK_MC;
				end
				tup_pkg::UNLOCK_SECOND: begin
					if (s_reg.st == tup_pkg::LK_FIRST && !expiring) begin
						s_next.st = tup_pkg::LK_OPEN;
						s_next.cnt = tup_pkg::WINDOW_MC;
					end else begin
						s_next.st = tup_pkg::LK_IDLE;
					end
				end
				default: s_next.st = tup_pkg::LK_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			s_reg <= '{st: tup_pkg::LK_IDLE, cnt: 2'h0};
		else
			s_reg <= s_next;
	end

	// Closing cycle already counts as outside
	assign lk.window_open = (s_reg.st == tup_pkg::LK_OPEN) && !expiring;
	assign lk.first_pending = (s_reg.st == tup_pkg::LK_FIRST);

	sequence s_second_in_time;
		lk.wr_stb && lk.wr_data == tup_pkg::UNLOCK_SECOND && lk.first_pending && !expiring;
	endsequence
	property p_open_after_sequence;
		@(posedge core_clk) disable iff (rst) s_second_in_time |=> (s_reg.st == tup_pkg::LK_OPEN);
	endproperty
	a_open_after_sequence: assert property (p_open_after_sequence)
		else $error("window did not open after timely second value");
	property p_late_second_fails;
		@(posedge core_clk) disable iff (rst)
			lk.wr_stb && lk.wr_data == tup_pkg::UNLOCK_SECOND && !lk.first_pending |=> !lk.window_open;
	endproperty
	a_late_second_fails: assert property (p_late_second_fails)
		else $error("window opened without a pending first value");
endmodule : tup_unlock_seq
`default_nettype wire

// ---- rtl/tup_isp_ctrl.sv ----
// Timed unlock protection and in-system programming control, Avalon-MM slave
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module tup_isp_ctrl (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [tup_pkg::REG_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Core sequencing
	input wire logic idle_wake,
	input wire logic reti_exec,
	output logic fetch_loader,
	output logic pc_clear,
	output logic stack_write,
	output logic [15:0] stack_data,
	output logic return_redirect,
	output logic [15:0] return_addr,
	output logic cpu_soft_reset,
	output logic clock_six_mode,
	// Flash arrays
	output logic isp_active,
	output logic [15:0] flash_addr,
	output logic [7:0] flash_wdata,
	output logic flash_bank,
	output logic flash_oe,
	output logic flash_ce,
	output logic [3:0] flash_op,
	output logic flash_erase,
	output logic flash_program,
	output logic flash_read,
	input wire logic [7:0] flash_rdata,
	input wire logic flash_rvalid
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [7:0] chip_programming_control;
		logic [7:0] clock_select_control;
		logic [7:0] isp_control_byte;
		logic [7:0] flash_address_high;
		logic [7:0] flash_address_low;
		logic [7:0] flash_program_data;
		logic isp_active;
		logic reti_pending;
		logic pc_clear;
		logic stack_write;
		logic ret_redir;
		logic soft_rst;
	} tup_ctrl_state_t;

	tup_ctrl_state_t s_reg, s_next;
	tup_unlock_if lk ();

	logic req;
	logic wr_take;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic prot_ok;
	logic [15:0] raw_addr;

	function automatic logic hit(input logic take, input logic [7:0] i, input logic [7:0] target);
		hit = take && (i == target);
	endfunction : hit

	function automatic logic op_is(input logic active, input logic [3:0] op, input logic [3:0] code);
		op_is = active && (op == code);
	endfunction : op_is

	tup_mc_tick #(
		.CNT_W(4)
	) u_tick (
		.core_clk(core_clk),
		.rst(rst),
		.six_mode(s_reg.clock_select_control[tup_pkg::CSC_SIX_BIT]),
		.mc_tick(lk.mc_tick)
	);

	tup_unlock_seq u_seq (
		.core_clk(core_clk),
		.rst(rst),
		.lk(lk.seq)
	);

	assign req = avs_read || avs_write;
	assign idx = avs_address[9:2];
	assign wbyte = avs_writedata[7:0];
	// Write lands on the edge where waitrequest is low
	assign wr_take = avs_write && s_reg.ack && avs_byteenable[0];
	assign prot_ok = lk.window_open;
	assign lk.wr_stb = hit(wr_take, idx, tup_pkg::IDX_UNLOCK);
	assign lk.wr_data = wbyte;

	always_comb begin
		case (idx)
			tup_pkg::IDX_CHIP_PROG: rbyte = s_reg.chip_programming_control;
			tup_pkg::IDX_CLOCK_SELECT: rbyte = s_reg.clock_select_control;
			tup_pkg::IDX_ISP_CONTROL: rbyte = s_reg.isp_control_byte & tup_pkg::ISP_WRITE_MASK;
			tup_pkg::IDX_FLASH_ADDR_HIGH: rbyte = s_reg.flash_address_high;
			tup_pkg::IDX_FLASH_ADDR_LOW: rbyte = s_reg.flash_address_low;
			tup_pkg::IDX_FLASH_DATA: rbyte = s_reg.flash_program_data;
			tup_pkg::IDX_STATUS: rbyte = {3'h0, s_reg.clock_select_control[tup_pkg::CSC_SIX_BIT],
				s_reg.reti_pending, s_reg.isp_active, lk.first_pending, lk.window_open};
			default: rbyte = 8'h00;
		endcase
	end

	always_comb begin
		s_next = s_reg;
		s_next.pc_clear = 1'b0;
		s_next.stack_write = 1'b0;
		s_next.ret_redir = 1'b0;
		s_next.soft_rst = 1'b0;
		s_next.ack = req && !s_reg.ack;
		if (req && !s_reg.ack)
			s_next.rdata = {24'h000000, rbyte};
		if (hit(wr_take, idx, tup_pkg::IDX_CLOCK_SELECT) && prot_ok)
			s_next.clock_select_control = wbyte;
		if (hit(wr_take, idx, tup_pkg::IDX_ISP_CONTROL))
			s_next.isp_control_byte = wbyte & tup_pkg::ISP_WRITE_MASK;
		if (hit(wr_take, idx, tup_pkg::IDX_FLASH_ADDR_HIGH))
			s_next.flash_address_high = wbyte;
		if (hit(wr_take, idx, tup_pkg::IDX_FLASH_ADDR_LOW))
			s_next.flash_address_low = wbyte;
		if (hit(wr_take, idx, tup_pkg::IDX_FLASH_DATA))
			s_next.flash_program_data = wbyte;
		// Flash read data return wins over a software write
		if (s_reg.isp_active && flash_rvalid && flash_read)
			s_next.flash_program_data = flash_rdata;
		if (reti_exec && s_reg.reti_pending) begin
			s_next.ret_redir = 1'b1;
			s_next.reti_pending = 1'b0;
		end
		if (idle_wake && s_reg.chip_programming_control[tup_pkg::CPC_ARM_BIT] && !s_reg.isp_active) begin
			s_next.isp_active = 1'b1;
			s_next.pc_clear = 1'b1;
			s_next.stack_write = 1'b1;
			s_next.reti_pending = 1'b1;
		end
		if (hit(wr_take, idx, tup_pkg::IDX_CHIP_PROG) && prot_ok) begin
			s_next.chip_programming_control = wbyte;
			if ((wbyte & tup_pkg::CPC_SOFT_RESET_MASK) == tup_pkg::CPC_SOFT_RESET_MASK) begin
				s_next.soft_rst = 1'b1;
				s_next.isp_active = 1'b0;
				s_next.reti_pending = 1'b0;
				s_next.pc_clear = 1'b0;
				s_next.stack_write = 1'b0;
				s_next.chip_programming_control = tup_pkg::REG_RESET;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.chip_programming_control <= tup_pkg::REG_RESET;
			s_reg.clock_select_control <= tup_pkg::REG_RESET;
			s_reg.isp_control_byte <= tup_pkg::REG_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// Bus answer: one wait cycle on every access
	assign avs_waitrequest = req && !s_reg.ack;
	assign avs_readdata = s_reg.rdata;

	// Core sequencing
	assign isp_active = s_reg.isp_active;
	assign fetch_loader = s_reg.isp_active;
	assign pc_clear = s_reg.pc_clear;
	assign stack_write = s_reg.stack_write;
	assign stack_data = tup_pkg::STACK_INIT_WORD;
	assign return_redirect = s_reg.ret_redir;
	assign return_addr = tup_pkg::LOADER_RETURN_ADDR;
	assign cpu_soft_reset = s_reg.soft_rst;
	assign clock_six_mode = s_reg.clock_select_control[tup_pkg::CSC_SIX_BIT];

	// Flash drive from the address, data and control bytes
	assign raw_addr = {s_reg.flash_address_high, s_reg.flash_address_low};
	assign flash_bank = s_reg.isp_control_byte[tup_pkg::ISP_BANK_BIT];
	// Loader bank only decodes its own span
	assign flash_addr = flash_bank ? {{(16-tup_pkg::LOADER_AW){1'b0}}, raw_addr[tup_pkg::LOADER_AW-1:0]} : raw_addr;
	assign flash_wdata = s_reg.flash_program_data;
	assign flash_oe = s_reg.isp_control_byte[tup_pkg::ISP_OE_BIT];
	assign flash_ce = s_reg.isp_control_byte[tup_pkg::ISP_CE_BIT];
	assign flash_op = s_reg.isp_control_byte[3:0];
	assign flash_erase = op_is(s_reg.isp_active, flash_op, tup_pkg::OP_ERASE);
	assign flash_program = op_is(s_reg.isp_active, flash_op, tup_pkg::OP_PROGRAM);
	assign flash_read = op_is(s_reg.isp_active, flash_op, tup_pkg::OP_READ);

	sequence s_prot_write_closed;
		wr_take && (idx == tup_pkg::IDX_CHIP_PROG) && !lk.window_open;
	endsequence
	property p_protected_discard;
		@(posedge core_clk) disable iff (rst)
			s_prot_write_closed |=> (s_reg.chip_programming_control == $past(s_reg.chip_programming_control));
	endproperty
	a_protected_discard: assert property (p_protected_discard)
		else $error("protected write landed outside the window");

	property p_clock_select_guard;
		@(posedge core_clk) disable iff (rst)
			!$stable(s_reg.clock_select_control) |->
			$past(lk.window_open && wr_take && idx == tup_pkg::IDX_CLOCK_SELECT);
	endproperty
	a_clock_select_guard: assert property (p_clock_select_guard)
		else $error("clock select changed without unlock");

	property p_window_bounded;
		@(posedge core_clk) disable iff (rst)
			$rose(lk.window_open) |-> ##[1:60] !lk.window_open;
	endproperty
	a_window_bounded: assert property (p_window_bounded)
		else $error("write window stayed open too long");

	property p_other_value_locks;
		@(posedge core_clk) disable iff (rst)
			lk.wr_stb && wbyte != tup_pkg::UNLOCK_FIRST && wbyte != tup_pkg::UNLOCK_SECOND
			|=> !lk.window_open && !lk.first_pending;
	endproperty
	a_other_value_locks: assert property (p_other_value_locks)
		else $error("foreign unlock value left permission open");

	property p_first_starts_countdown;
		@(posedge core_clk) disable iff (rst)
			lk.wr_stb && wbyte == tup_pkg::UNLOCK_FIRST |=> lk.first_pending ##[0:60] !lk.first_pending;
	endproperty
	a_first_starts_countdown: assert property (p_first_starts_countdown)
		else $error("first unlock value countdown misbehaved");

	sequence s_armed_wake;
		idle_wake && s_reg.chip_programming_control[tup_pkg::CPC_ARM_BIT] && !s_reg.isp_active
		&& !(wr_take && idx == tup_pkg::IDX_CHIP_PROG && lk.window_open);
	endsequence
	property p_wake_entry;
		@(posedge core_clk) disable iff (rst)
			s_armed_wake |=> fetch_loader && pc_clear && stack_write && stack_data == 16'h0000;
	endproperty
	a_wake_entry: assert property (p_wake_entry)
		else $error("wake did not enter programming mode");

	property p_entry_needs_wake;
		@(posedge core_clk) disable iff (rst)
			$rose(isp_active) |-> $past(idle_wake);
	endproperty
	a_entry_needs_wake: assert property (p_entry_needs_wake)
		else $error("programming mode entered without wake");

	property p_first_return;
		@(posedge core_clk) disable iff (rst)
			reti_exec && s_reg.reti_pending && !cpu_soft_reset
			&& !(wr_take && idx == tup_pkg::IDX_CHIP_PROG && lk.window_open)
			|=> return_redirect && return_addr == 16'h0000 ##1 !s_reg.reti_pending;
	endproperty
	a_first_return: assert property (p_first_return)
		else $error("first return not sent to loader zero");

	property p_soft_reset;
		@(posedge core_clk) disable iff (rst)
			wr_take && idx == tup_pkg::IDX_CHIP_PROG && lk.window_open && (wbyte & 8'h83) == 8'h83
			|=> cpu_soft_reset && !fetch_loader ##1 !cpu_soft_reset;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("software reset sequence wrong");

	property p_flash_pins;
		@(posedge core_clk) disable iff (rst)
			flash_oe == s_reg.isp_control_byte[5] && flash_ce == s_reg.isp_control_byte[4]
			&& flash_bank == s_reg.isp_control_byte[6] && !s_reg.isp_control_byte[7];
	endproperty
	a_flash_pins: assert property (p_flash_pins)
		else $error("flash control pins disagree with control byte");

	property p_bus_answer;
		@(posedge core_clk) disable iff (rst)
			req && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus answer later than one wait cycle");

	property p_open_write_lands;
		@(posedge core_clk) disable iff (rst)
			wr_take && idx == tup_pkg::IDX_CHIP_PROG && lk.window_open && (wbyte & 8'h83) != 8'h83
			|=> s_reg.chip_programming_control == $past(wbyte);
	endproperty
	a_open_write_lands: assert property (p_open_write_lands)
		else $error("unlocked write to programming control lost");

	property p_entry_pulses_single;
		@(posedge core_clk) disable iff (rst)
			pc_clear |-> stack_write ##1 (!pc_clear && !stack_write);
	endproperty
	a_entry_pulses_single: assert property (p_entry_pulses_single)
		else $error("entry pulses not single cycle");

	property p_loader_span;
		@(posedge core_clk) disable iff (rst)
			flash_bank |-> flash_addr[15:tup_pkg::LOADER_AW] == '0;
	endproperty
	a_loader_span: assert property (p_loader_span)
		else $error("loader bank address outside its span");

	property p_strobes_need_mode;
		@(posedge core_clk) disable iff (rst)
			!isp_active |-> !(flash_erase || flash_program || flash_read);
	endproperty
	a_strobes_need_mode: assert property (p_strobes_need_mode)
		else $error("flash strobe outside programming mode");

	property p_soft_reset_clears;
		@(posedge core_clk) disable iff (rst)
			cpu_soft_reset |-> !isp_active && s_reg.chip_programming_control == 8'h00;
	endproperty
	a_soft_reset_clears: assert property (p_soft_reset_clears)
		else $error("software reset left programming state");
endmodule : tup_isp_ctrl
`default_nettype wire

// ---- verif/tup_flash_model.sv ----
// Flash array stand-in that answers reads after a delay
`timescale 1ns/1ps
`default_nettype none
module tup_flash_model #(
	parameter int DLY = 3
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Flash side
	input wire logic flash_read,
	input wire logic [15:0] flash_addr,
	output logic [7:0] flash_rdata,
	output logic flash_rvalid
);
	int cnt;
	always_ff @(posedge core_clk) begin
		if (rst || !flash_read) begin
			cnt <= 0;
			flash_rvalid <= 1'b0;
		end else begin
			cnt <= (cnt == DLY) ? 0 : cnt + 1;
			flash_rvalid <= (cnt == DLY);
		end
		// Stale data inverted so nobody can rely on it
		if (rst)
			flash_rdata <= 8'h00;
		else if (flash_read && cnt == DLY)
			flash_rdata <= flash_addr[15:8] ^ flash_addr[7:0] ^ 8'h5a;
		else
			flash_rdata <= ~flash_rdata;
	end
endmodule : tup_flash_model
`default_nettype wire

// ---- verif/tup_isp_ctrl_tb_top.sv ----
// Self-checking bench for the timed unlock and programming block
`timescale 1ns/1ps
`default_nettype none
module tup_isp_ctrl_tb_top;
	localparam logic [7:0] CP = tup_pkg::IDX_CHIP_PROG;
	localparam logic [7:0] CS = tup_pkg::IDX_CLOCK_SELECT;
	localparam logic [7:0] UL = tup_pkg::IDX_UNLOCK;
	localparam logic [7:0] ST = tup_pkg::IDX_STATUS;
	localparam logic [7:0] IC = tup_pkg::IDX_ISP_CONTROL;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [9:0] avs_address = 10'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic idle_wake = 1'b0;
	logic reti_exec = 1'b0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, fetch_loader, pc_clear, stack_write, return_redirect, cpu_soft_reset;
	logic clock_six_mode, isp_active, flash_bank, flash_oe, flash_ce, flash_erase, flash_program;
	logic flash_read, flash_rvalid;
	logic [15:0] stack_data, return_addr, flash_addr;
	logic [7:0] flash_wdata, flash_rdata;
	logic [3:0] flash_op;
	int fail_count = 0;
	int samples_checked = 0;
	int n_pc, n_stk, n_ret, n_soft;

	tup_isp_ctrl tup_isp_ctrl_i (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .idle_wake, .reti_exec, .fetch_loader, .pc_clear,
		.stack_write, .stack_data, .return_redirect, .return_addr, .cpu_soft_reset, .clock_six_mode,
		.isp_active, .flash_addr, .flash_wdata, .flash_bank, .flash_oe, .flash_ce, .flash_op, .flash_erase,
		.flash_program, .flash_read, .flash_rdata, .flash_rvalid);
	tup_flash_model #(.DLY(3)) tup_flash_model_i (.core_clk, .rst, .flash_read, .flash_addr, .flash_rdata,
		.flash_rvalid);

	always #2 core_clk = ~core_clk;
	// Pulse widths counted in cycles
	always @(posedge core_clk) begin
		n_pc += (pc_clear === 1'b1);
		n_stk += (stack_write === 1'b1);
		n_ret += (return_redirect === 1'b1);
		n_soft += (cpu_soft_reset === 1'b1);
	end

	task automatic print_verdict();
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
		logic w;
		w = 1'b1;
		@(posedge core_clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		// Waitrequest and read data as sampled at the rising edge
		for (int i = 0; i < 20 && w !== 1'b0; i++) begin
			@(posedge core_clk);
			w = avs_waitrequest;
			q = avs_readdata;
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (w !== 1'b0) begin
			fail_count++;
			print_verdict();
		end
	endtask : bus

	// Write whose effect lands gap clocks after the previous access
	task automatic wr(input int gap, input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		repeat (gap - 3) @(posedge core_clk);
		bus(1'b1, idx, d, q);
	endtask : wr

	task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, idx, 8'h00, q);
		chk(nm, {24'h0, e}, q);
	endtask : rdchk

	task automatic tsq(input int g1, input int g2, input logic [7:0] idx, input logic [7:0] v);
		wr(3, UL, tup_pkg::UNLOCK_FIRST);
		wr(g1, UL, tup_pkg::UNLOCK_SECOND);
		wr(g2, idx, v);
		@(negedge core_clk);
	endtask : tsq

	task automatic pulse(input logic sel);
		@(posedge core_clk);
		if (sel) idle_wake <= 1'b1;
		else reti_exec <= 1'b1;
		@(posedge core_clk);
		idle_wake <= 1'b0;
		reti_exec <= 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
	endtask : pulse

	task automatic t_reset_state();
		rdchk("chip_programming", CP, 8'h00);
		chk("fetch_loader", 1'b0, fetch_loader);
		wr(3, CP, 8'h02);
		rdchk("chip_programming", CP, 8'h00);
		wr(3, CS, 8'h01);
		@(negedge core_clk);
		chk("clock_six_mode", 1'b0, clock_six_mode);
	endtask : t_reset_state

	task automatic t_pending();
		wr(3, UL, tup_pkg::UNLOCK_FIRST);
		rdchk("status", ST, 8'h02);
		repeat (50) @(posedge core_clk);
		rdchk("status", ST, 8'h00);
	endtask : t_pending

	task automatic t_timing();
		tsq(36, 36, CP, 8'h02);
		rdchk("chip_programming", CP, 8'h02);
		tsq(48, 3, CP, 8'h00);
		rdchk("chip_programming", CP, 8'h02);
		tsq(3, 48, CP, 8'h00);
		rdchk("chip_programming", CP, 8'h02);
		tsq(3, 3, CP, 8'h00);
		rdchk("chip_programming", CP, 8'h00);
	endtask : t_timing

	task automatic t_withdraw();
		wr(3, UL, tup_pkg::UNLOCK_FIRST);
		wr(3, UL, tup_pkg::UNLOCK_SECOND);
		wr(3, UL, 8'h00);
		wr(3, CP, 8'h02);
		rdchk("chip_programming", CP, 8'h00);
	endtask : t_withdraw

	task automatic t_clock();
		tsq(3, 3, CS, 8'h01);
		chk("clock_six_mode", 1'b1, clock_six_mode);
		// Window still open at this read
		rdchk("status", ST, 8'h11);
		tsq(24, 3, CP, 8'h02);
		rdchk("chip_programming", CP, 8'h00);
		tsq(18, 3, CS, 8'h00);
		chk("clock_six_mode", 1'b0, clock_six_mode);
	endtask : t_clock

	task automatic t_isp();
		tsq(3, 3, CP, 8'h01);
		repeat (30) @(posedge core_clk);
		chk("isp_active", 1'b0, isp_active);
		n_pc = 0;
		n_stk = 0;
		n_ret = 0;
		pulse(1'b1);
		chk("isp_active", 1'b1, isp_active);
		chk("fetch_loader", 1'b1, fetch_loader);
		chk("pc_clear", 1, n_pc);
		chk("stack_write", 1, n_stk);
		chk("stack_data", 16'h0000, stack_data);
		pulse(1'b0);
		pulse(1'b0);
		chk("return_redirect", 1, n_ret);
		chk("return_addr", 16'h0000, return_addr);
	endtask : t_isp

	task automatic t_flash();
		logic [3:0] op;
		logic [7:0] ctl;
		wr(3, tup_pkg::IDX_FLASH_ADDR_HIGH, 8'hab);
		wr(3, tup_pkg::IDX_FLASH_ADDR_LOW, 8'hcd);
		for (int b = 0; b < 2; b++) begin
			// Leave the read op first, or read returns overwrite the data
			wr(3, IC, 8'h02);
			wr(3, tup_pkg::IDX_FLASH_DATA, 8'h3c);
			for (int k = 0; k < 3; k++) begin
				op = 4'(2 - k);
				ctl = {1'b1, b[0], op != 4'h0, 1'b0, op};
				wr(3, IC, ctl);
				@(negedge core_clk);
				chk("flash_addr", b ? 16'h0bcd : 16'habcd, flash_addr);
				chk("flash_wdata", 8'h3c, flash_wdata);
				chk("flash_pins", ctl[6:0], {flash_bank, flash_oe, flash_ce, flash_op});
				chk("flash_strobes", {op == 2, op == 1, op == 0}, {flash_erase, flash_program, flash_read});
				rdchk("isp_control", IC, {1'b0, ctl[6:0]});
			end
			repeat (12) @(posedge core_clk);
			rdchk("flash_data", tup_pkg::IDX_FLASH_DATA, (b ? 8'h0b : 8'hab) ^ 8'hcd ^ 8'h5a);
		end
	endtask : t_flash

	task automatic t_soft();
		n_soft = 0;
		tsq(3, 3, CP, 8'h83);
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk("cpu_soft_reset", 1, n_soft);
		chk("fetch_loader", 1'b0, fetch_loader);
		rdchk("chip_programming", CP, 8'h00);
	endtask : t_soft

	task automatic t_midreset();
		tsq(3, 3, CP, 8'h01);
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rdchk("status", ST, 8'h00);
		pulse(1'b1);
		chk("isp_active", 1'b0, isp_active);
	endtask : t_midreset

	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		t_reset_state();
		t_pending();
		t_timing();
		t_withdraw();
		t_clock();
		t_isp();
		t_flash();
		t_soft();
		t_midreset();
		print_verdict();
	end
endmodule : tup_isp_ctrl_tb_top
`default_nettype wire
